// *** adc_control_register_block.sv ***
`timescale 1ns/1ps
// What this block does
// - registers decoded at fixed base plus offsets
// - unbypassed filter puts code in upper half
// - bypassed filter puts code in lower half
// - power and start ignored in microphone mode
// - calibrate only with both enable bits set
// - calibration enable cleared only by clear bit or register reset bit
// - start begins conversion when powered on
// - register reset bit restores command, setup, result and limit defaults, reads zero
// - stop clears start, power, dma, microphone
// - read-only result word at 0x14
// - offset correction register at 0x18, resets zero
// - window limits at 0x24 and 0x28
// - masked status 0x08, raw status 0x10
// - mask register at 0x0C resets 0xF
// - busy set and setup frozen during conversion
// - store corrected result, raise done flag
// - window flag when result inside limits
// - stop ends continuous conversion, powers off
module adc_control_register_block
    import adc_ctrl_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire apb_req_t    i_apb,
    input  wire logic [15:0] i_sample,
    input  wire logic        i_sample_valid,
    output logic [31:0]      o_prdata,
    output logic             o_irq,
    output logic             o_analog_on,
    output logic             o_busy,
    output logic             o_filter_bypass,
    output logic [1:0]       o_osr,
    output logic [1:0]       o_attenuation,
    output logic             o_microphone_enable,
    output logic             o_dma_en
);

    logic [CMD_W-1:0]   cmd_reg;
    logic [CMD_W-1:0]   cmd_next;
    logic [SETUP_W-1:0] setup_reg;
    logic [SETUP_W-1:0] setup_next;
    logic [FLAG_W-1:0]  raw_reg;
    logic [FLAG_W-1:0]  raw_next;
    logic [FLAG_W-1:0]  mask_reg;
    logic [31:0]        result_reg;
    logic [31:0]        zero_err_reg;
    logic [31:0]        zero_err_next;
    logic [31:0]        upper_reg;
    logic [31:0]        lower_reg;
    logic [31:0]        prdata_reg;
    logic               irq_reg;
    logic               analog_on_reg;
    logic               busy_reg;

    // bus decode
    wire                in_space  = (i_apb.addr[31:OFS_BITS] == BASE_ADDR[31:OFS_BITS]);
    wire [7:0]          ofs       = i_apb.addr[OFS_BITS-1:0];
    wire                setup_ph  = i_apb.sel & ~i_apb.enable & in_space;
    wire                wr        = i_apb.sel & i_apb.enable & i_apb.write & in_space;
    wire [31:0]         wd        = i_apb.wdata;
    wire                wr_cmd    = wr & (ofs == OFS_COMMAND);
    wire                wr_setup  = wr & (ofs == OFS_SETUP);
    wire                wr_mask   = wr & (ofs == OFS_MASK);
    wire                wr_zero   = wr & (ofs == OFS_ZERO_ERR);
    wire                wr_state  = wr & (ofs == OFS_STATE);
    wire                wr_upper  = wr & (ofs == OFS_UPPER);
    wire                wr_lower  = wr & (ofs == OFS_LOWER);
    wire                soft_rst  = wr_cmd & wd[B_SOFTRST];
    wire                stop_cmd  = wr_cmd & wd[B_STOP];

    // sequencer hookup
    wire                skip      = setup_reg[B_SKIP];
    wire                start_ok  = cmd_reg[B_START] & cmd_reg[B_ON] & ~cmd_reg[B_MIC];
    wire                abort     = ~cmd_reg[B_ON] | cmd_reg[B_MIC] | stop_cmd | soft_rst;
    wire                cal_req   = cmd_reg[B_CALIBRATION_ENABLE] & cmd_reg[B_AUTO_OFS];
    wire                seq_busy;
    wire                cal_done;
    wire                conv_done;
    wire                started;

    conv_sequencer u_seq (
        .i_clk          (i_clk),
        .i_rst_b        (i_rst_b),
        .i_start        (start_ok),
        .i_continuous   (setup_reg[B_CONT]),
        .i_cal_req      (cal_req),
        .i_abort        (abort),
        .i_sample_valid (i_sample_valid),
        .o_busy         (seq_busy),
        .o_cal_done     (cal_done),
        .o_conv_done    (conv_done),
        .o_started      (started)
    );

    // result path
    wire [15:0]         zero_half = skip ? zero_err_reg[15:0] : zero_err_reg[31:16];
    wire [15:0]         corrected = i_sample - zero_half;
    wire [31:0]         result_new = skip ? {16'h0000, corrected} : {corrected, 16'h0000};
    wire                in_window = (result_new >= lower_reg) & (result_new <= upper_reg);
    wire                win_hit   = conv_done & cmd_reg[B_WINEN] & in_window;
    wire [FLAG_W-1:0]   flag_set  = {started, win_hit, cal_done, conv_done};
    wire [FLAG_W-1:0]   flag_clr  = wr_state ? wd[FLAG_W:1] : {FLAG_W{1'b0}};
    wire [FLAG_W-1:0]   masked    = raw_reg & mask_reg;

    // read mux, unmapped reads zero
    wire [31:0]         rd_mux =
        (ofs == OFS_COMMAND)  ? {22'h0, cmd_reg} :
        (ofs == OFS_SETUP)    ? {24'h0, setup_reg} :
        (ofs == OFS_MASKED)   ? {28'h0, masked} :
        (ofs == OFS_MASK)     ? {28'h0, mask_reg} :
        (ofs == OFS_RAW)      ? {28'h0, raw_reg} :
        (ofs == OFS_RESULT)   ? result_reg :
        (ofs == OFS_ZERO_ERR) ? zero_err_reg :
        (ofs == OFS_STATE)    ? {27'h0, raw_reg, seq_busy} :
        (ofs == OFS_UPPER)    ? upper_reg :
        (ofs == OFS_LOWER)    ? lower_reg : 32'h0000_0000;

    always_comb begin
        cmd_next = cmd_reg;
        if (wr_cmd) begin
            cmd_next          = wd[CMD_W-1:0] & CMD_STORE_MASK;
            cmd_next[B_CALIBRATION_ENABLE] = cmd_reg[B_CALIBRATION_ENABLE] | wd[B_CALIBRATION_ENABLE];
            if (wd[B_CALIBRATION_ENABLE_CLEAR]) begin
                cmd_next[B_CALIBRATION_ENABLE] = 1'b0;
            end
        end
        if (conv_done && !setup_reg[B_CONT]) begin
            cmd_next[B_START] = 1'b0;
        end
        if (stop_cmd) begin
            cmd_next[B_START] = 1'b0;
            cmd_next[B_ON]    = 1'b0;
            cmd_next[B_DMA]   = 1'b0;
            cmd_next[B_MIC]   = 1'b0;
        end
        if (soft_rst) begin
            cmd_next = CMD_RESET;
        end
    end

    always_comb begin
        setup_next = setup_reg;
        if (wr_setup && !seq_busy) begin
            setup_next = wd[SETUP_W-1:0];
        end
        if (soft_rst) begin
            setup_next = SETUP_RESET;
        end
    end

    always_comb begin
        zero_err_next = zero_err_reg;
        if (wr_zero) begin
            zero_err_next = wd;
        end
        if (cal_done && skip) begin
            zero_err_next[15:0] = i_sample;
        end
        if (cal_done && !skip) begin
            zero_err_next[31:16] = i_sample;
        end
    end

    assign raw_next = (raw_reg & ~flag_clr) | flag_set;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_reg      <= CMD_RESET;
            setup_reg    <= SETUP_RESET;
            raw_reg      <= '0;
            mask_reg     <= MASK_RESET;
            zero_err_reg <= ZERO_ERR_RESET;
        end else begin
            cmd_reg      <= cmd_next;
            setup_reg    <= setup_next;
            raw_reg      <= raw_next;
            mask_reg     <= wr_mask ? wd[FLAG_W-1:0] : mask_reg;
            zero_err_reg <= zero_err_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            result_reg <= RESULT_RESET;
            upper_reg  <= UPPER_RESET;
            lower_reg  <= LOWER_RESET;
        end else if (soft_rst) begin
            result_reg <= RESULT_RESET;
            upper_reg  <= UPPER_RESET;
            lower_reg  <= LOWER_RESET;
        end else begin
            result_reg <= conv_done ? result_new : result_reg;
            upper_reg  <= wr_upper ? wd : upper_reg;
            lower_reg  <= wr_lower ? wd : lower_reg;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            prdata_reg    <= '0;
            irq_reg       <= 1'b0;
            analog_on_reg <= 1'b0;
            busy_reg      <= 1'b0;
        end else begin
            prdata_reg    <= setup_ph ? rd_mux : 32'h0000_0000;
            irq_reg       <= |(raw_next & mask_reg);
            analog_on_reg <= cmd_next[B_ON] & ~cmd_next[B_MIC];
            busy_reg      <= seq_busy;
        end
    end

    assign o_prdata        = prdata_reg;
    assign o_irq           = irq_reg;
    assign o_analog_on     = analog_on_reg;
    assign o_busy          = busy_reg;
    assign o_filter_bypass = setup_reg[B_SKIP];
    assign o_osr           = setup_reg[B_OSR_LO+1:B_OSR_LO];
    assign o_attenuation   = setup_reg[B_ATT_LO+1:B_ATT_LO];
    assign o_microphone_enable        = cmd_reg[B_MIC];
    assign o_dma_en        = cmd_reg[B_DMA];

    // checks
    property p_upper_half;
        @(posedge i_clk) disable iff (!i_rst_b)
        conv_done && !skip && !soft_rst |=> result_reg[31:16] == $past(corrected) && result_reg[15:0] == 16'h0000;
    endproperty
    a_upper_half: assert property (p_upper_half) else $error("result not in upper half");

    property p_lower_half;
        @(posedge i_clk) disable iff (!i_rst_b)
        conv_done && skip && !soft_rst |=> result_reg[15:0] == $past(corrected) && result_reg[31:16] == 16'h0000;
    endproperty
    a_lower_half: assert property (p_lower_half) else $error("result not in lower half");

    property p_mic_blocks;
        @(posedge i_clk) disable iff (!i_rst_b)
        cmd_reg[B_MIC] && !seq_busy |=> !seq_busy;
    endproperty
    a_mic_blocks: assert property (p_mic_blocks) else $error("conversion began in microphone mode");

    property p_cal_store;
        @(posedge i_clk) disable iff (!i_rst_b)
        cal_done |=> ($past(skip) ? zero_err_reg[15:0] : zero_err_reg[31:16]) == $past(i_sample);
    endproperty
    a_cal_store: assert property (p_cal_store) else $error("calibration result not stored");

    property p_calibration_enable_sticky;
        @(posedge i_clk) disable iff (!i_rst_b)
        cmd_reg[B_CALIBRATION_ENABLE] && !(wr_cmd && (wd[B_CALIBRATION_ENABLE_CLEAR] || wd[B_SOFTRST])) |=> cmd_reg[B_CALIBRATION_ENABLE];
    endproperty
    a_calibration_enable_sticky: assert property (p_calibration_enable_sticky) else $error("calibration enable dropped");

    property p_start_begins;
        @(posedge i_clk) disable iff (!i_rst_b)
        start_ok && !abort && !seq_busy |=> seq_busy [*2];
    endproperty
    a_start_begins: assert property (p_start_begins) else $error("start did not begin conversion");

    property p_soft_reset;
        @(posedge i_clk) disable iff (!i_rst_b)
        soft_rst |=> cmd_reg == CMD_RESET && setup_reg == SETUP_RESET && upper_reg == UPPER_RESET;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("register reset incomplete");

    property p_stop;
        @(posedge i_clk) disable iff (!i_rst_b)
        stop_cmd |=> !cmd_reg[B_ON] && !cmd_reg[B_START] && !cmd_reg[B_MIC] && !cmd_reg[B_DMA] && !seq_busy;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not switch off");

    property p_setup_frozen;
        @(posedge i_clk) disable iff (!i_rst_b)
        seq_busy && !soft_rst |=> $stable(setup_reg);
    endproperty
    a_setup_frozen: assert property (p_setup_frozen) else $error("setup changed while busy");

    property p_done_flag;
        @(posedge i_clk) disable iff (!i_rst_b)
        conv_done |=> raw_reg[F_EOC] ##1 o_irq || !mask_reg[F_EOC];
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("done flag or interrupt missing");

    property p_masked_read;
        @(posedge i_clk) disable iff (!i_rst_b)
        setup_ph && ofs == OFS_MASKED |=> o_prdata[FLAG_W-1:0] == ($past(raw_reg) & $past(mask_reg));
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked view wrong");

    property p_unmapped;
        @(posedge i_clk) disable iff (!i_rst_b)
        setup_ph && (ofs == 8'h1C || ofs > OFS_LOWER) |=> o_prdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    c_calibrated: cover property (@(posedge i_clk) disable iff (!i_rst_b) cal_done ##[1:1000] conv_done);
    c_window_hit: cover property (@(posedge i_clk) disable iff (!i_rst_b) win_hit);
    c_stop_busy: cover property (@(posedge i_clk) disable iff (!i_rst_b) seq_busy && stop_cmd);

endmodule // adc_control_register_block

// *** adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

    localparam logic [31:0] BASE_ADDR      = 32'h4080_0000;
    localparam int          OFS_BITS       = 8;

    localparam logic [7:0]  OFS_COMMAND    = 8'h00;
    localparam logic [7:0]  OFS_SETUP      = 8'h04;
    localparam logic [7:0]  OFS_MASKED     = 8'h08;
    localparam logic [7:0]  OFS_MASK       = 8'h0C;
    localparam logic [7:0]  OFS_RAW        = 8'h10;
    localparam logic [7:0]  OFS_RESULT     = 8'h14;
    localparam logic [7:0]  OFS_ZERO_ERR   = 8'h18;
    localparam logic [7:0]  OFS_STATE      = 8'h20;
    localparam logic [7:0]  OFS_UPPER      = 8'h24;
    localparam logic [7:0]  OFS_LOWER      = 8'h28;

    // converter_command fields
    localparam int          CMD_W          = 10;
    localparam int          B_ON           = 0;
    localparam int          B_CALIBRATION_ENABLE        = 1;
    localparam int          B_START        = 2;
    localparam int          B_SOFTRST      = 3;
    localparam int          B_STOP         = 4;
    localparam int          B_WINEN        = 5;
    localparam int          B_CALIBRATION_ENABLE_CLEAR     = 6;
    localparam int          B_AUTO_OFS     = 7;
    localparam int          B_MIC          = 8;
    localparam int          B_DMA          = 9;
    localparam logic [9:0]  CMD_STORE_MASK = 10'h3A7;
    localparam logic [9:0]  CMD_RESET      = 10'h000;

    // converter_setup fields
    localparam int          SETUP_W        = 8;
    localparam int          B_OSR_LO       = 2;
    localparam int          B_ATT_LO       = 4;
    localparam int          B_SKIP         = 6;
    localparam int          B_CONT         = 7;
    localparam logic [7:0]  SETUP_RESET    = 8'h0C;

    // event flags
    localparam int          FLAG_W         = 4;
    localparam int          F_EOC          = 0;
    localparam int          F_ENDCAL       = 1;
    localparam int          F_WIN          = 2;
    localparam int          F_STARTED      = 3;
    localparam logic [3:0]  MASK_RESET     = 4'hF;

    localparam logic [31:0] UPPER_RESET    = 32'h0FFF_FFFF;
    localparam logic [31:0] LOWER_RESET    = 32'h0000_0000;
    localparam logic [31:0] ZERO_ERR_RESET = 32'h0000_0000;
    localparam logic [31:0] RESULT_RESET   = 32'h0000_0000;

    localparam int          CLK_PERIOD_NS  = 20;
    localparam int          WAKE_TIME_NS   = 6000;
    localparam int          WAKE_CYCLES    = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          WAKE_CNT_W     = 9;

    typedef struct packed {
        logic        sel;
        logic        enable;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } apb_req_t;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_WAKE = 4'h2,
        S_CAL  = 4'h4,
        S_ACQ  = 4'h8
    } seq_state_t;

endpackage

// *** conv_sequencer.sv ***
`timescale 1ns/1ps
module conv_sequencer
    import adc_ctrl_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    input  wire logic i_start,
    input  wire logic i_continuous,
    input  wire logic i_cal_req,
    input  wire logic i_abort,
    input  wire logic i_sample_valid,
    output logic      o_busy,
    output logic      o_cal_done,
    output logic      o_conv_done,
    output logic      o_started
);

    seq_state_t             state_reg;
    seq_state_t             state_next;
    logic [WAKE_CNT_W-1:0]  wake_cnt_reg;
    logic [WAKE_CNT_W-1:0]  wake_cnt_next;

    localparam logic [WAKE_CNT_W-1:0] WAKE_LAST = WAKE_CNT_W'(WAKE_CYCLES - 1);

    assign o_busy      = (state_reg != S_IDLE);
    assign o_cal_done  = (state_reg == S_CAL) & i_sample_valid & ~i_abort;
    assign o_conv_done = (state_reg == S_ACQ) & i_sample_valid & ~i_abort;
    assign o_started   = (state_reg == S_IDLE) & i_start & ~i_abort;

    always_comb begin
        state_next    = state_reg;
        wake_cnt_next = wake_cnt_reg;
        case (state_reg)
            S_IDLE: begin
                wake_cnt_next = '0;
                if (o_started) begin
                    state_next = S_WAKE;
                end
            end
            S_WAKE: begin
                wake_cnt_next = wake_cnt_reg + 1'b1;
                if (wake_cnt_reg == WAKE_LAST) begin
                    state_next = i_cal_req ? S_CAL : S_ACQ;
                end
            end
            S_CAL: begin
                if (i_sample_valid) begin
                    state_next = S_ACQ;
                end
            end
            S_ACQ: begin
                if (i_sample_valid && !i_continuous) begin
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_IDLE;
            end
        endcase
        if (i_abort) begin
            state_next = S_IDLE;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg    <= S_IDLE;
            wake_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            wake_cnt_reg <= wake_cnt_next;
        end
    end

endmodule // conv_sequencer

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    import adc_ctrl_pkg::*;

    logic        i_clk          = 1'b0;
    logic        i_rst_b        = 1'b0;
    apb_req_t    i_apb          = '0;
    logic [15:0] i_sample       = 16'h0000;
    logic        i_sample_valid = 1'b0;
    logic [31:0] o_prdata;
    logic        o_irq;
    logic        o_analog_on;
    logic        o_busy;
    logic        o_filter_bypass;
    logic [1:0]  o_osr;
    logic [1:0]  o_attenuation;
    logic        o_microphone_enable;
    logic        o_dma_en;
    int          n_fail         = 0;
    int          n_checks       = 0;
    logic [31:0] exp_q[$];
    logic [7:0]  ofs_q[$];
    logic [31:0] ofs_v;
    logic [31:0] res_v;
    logic [15:0] s1;
    logic [15:0] s2;
    logic        win;
    logic [7:0]  rofs [11] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20, 8'h24, 8'h28, 8'h1C};
    logic [31:0] rval [11] = '{32'h0, 32'hC, 32'h0, 32'hF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0FFF_FFFF, 32'h0, 32'h0};

    always #10 i_clk = ~i_clk;

    adc_control_register_block i_dut (
        .i_clk           (i_clk),
        .i_rst_b         (i_rst_b),
        .i_apb           (i_apb),
        .i_sample        (i_sample),
        .i_sample_valid  (i_sample_valid),
        .o_prdata        (o_prdata),
        .o_irq           (o_irq),
        .o_analog_on     (o_analog_on),
        .o_busy          (o_busy),
        .o_filter_bypass (o_filter_bypass),
        .o_osr           (o_osr),
        .o_attenuation   (o_attenuation),
        .o_microphone_enable        (o_microphone_enable),
        .o_dma_en        (o_dma_en)
    );

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // read data checked in the access cycle
    always @(posedge i_clk) begin
        if (i_apb.sel && i_apb.enable && !i_apb.write) begin
            chk($sformatf("read %h", ofs_q.pop_front()), exp_q.pop_front(), o_prdata);
        end
    end

    task automatic xfer(input logic we, input logic [7:0] ofs, input logic [31:0] d);
        if (!we) begin
            exp_q.push_back(d);
            ofs_q.push_back(ofs);
        end
        i_apb <= '{1'b1, 1'b0, we, BASE_ADDR | {24'h0, ofs}, we ? d : 32'h0};
        @(posedge i_clk);
        i_apb.enable <= 1'b1;
        @(posedge i_clk);
        i_apb <= '0;
        @(posedge i_clk);
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d);
        xfer(1'b1, ofs, d);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [31:0] e);
        xfer(1'b0, ofs, e);
    endtask

    task automatic pulse(input logic [15:0] s);
        i_sample       <= s;
        i_sample_valid <= 1'b1;
        @(posedge i_clk);
        i_sample_valid <= 1'b0;
        i_sample       <= ~s;
        @(posedge i_clk);
    endtask

    task automatic wait_busy(input logic lvl);
        int k;
        k = 0;
        while (o_busy !== lvl && k < 1000) begin
            @(posedge i_clk);
            k++;
        end
        chk("busy", {31'h0, lvl}, {31'h0, o_busy});
    endtask

    // single conversion, optional calibration sample first
    task automatic conv(input logic [31:0] cmd, input logic cal);
        wr(OFS_COMMAND, cmd);
        wait_busy(1'b1);
        repeat (310) @(posedge i_clk);
        if (cal) begin
            pulse(s1);
        end
        repeat (4) @(posedge i_clk);
        pulse(s2);
        wait_busy(1'b0);
        repeat (3) @(posedge i_clk);
    endtask

    initial begin
        #200_000;
        n_fail++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'h64FB));
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        @(posedge i_clk);
        chk("osr", 32'h3, {30'h0, o_osr});
        foreach (rofs[i]) rd(rofs[i], rval[i]);
        ofs_v = $urandom();
        wr(OFS_ZERO_ERR, ofs_v);
        rd(OFS_ZERO_ERR, ofs_v);
        wr(OFS_RESULT, 32'hFFFF_FFFF);
        rd(OFS_RESULT, 32'h0);
        wr(8'h1C, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0);
        // calibration enable sticky
        wr(OFS_COMMAND, 32'h2);
        wr(OFS_COMMAND, 32'h0);
        rd(OFS_COMMAND, 32'h2);
        wr(OFS_COMMAND, 32'h40);
        rd(OFS_COMMAND, 32'h0);
        // microphone mode blocks power and start
        wr(OFS_COMMAND, 32'h105);
        repeat (3) @(posedge i_clk);
        chk("analog_on", 32'h0, {31'h0, o_analog_on});
        chk("busy", 32'h0, {31'h0, o_busy});
        chk("microphone_enable", 32'h1, {31'h0, o_microphone_enable});
        wr(OFS_COMMAND, 32'h10);
        rd(OFS_COMMAND, 32'h0);
        // conversion, filter in path, window on
        wr(OFS_UPPER, 32'h8000_0000);
        wr(OFS_LOWER, 32'h0001_0000);
        s2 = 16'($urandom());
        conv(32'h25, 1'b0);
        res_v = {s2 - ofs_v[31:16], 16'h0};
        win = (res_v >= 32'h0001_0000) && (res_v <= 32'h8000_0000);
        rd(OFS_RESULT, res_v);
        rd(OFS_RAW, {28'h0, 1'b1, win, 2'b01});
        rd(OFS_COMMAND, 32'h21);
        chk("irq", 32'h1, {31'h0, o_irq});
        wr(OFS_MASK, 32'h0);
        rd(OFS_MASKED, 32'h0);
        chk("irq", 32'h0, {31'h0, o_irq});
        wr(OFS_MASK, 32'h1);
        rd(OFS_MASKED, 32'h1);
        wr(OFS_STATE, 32'h1E);
        rd(OFS_RAW, 32'h0);
        wr(OFS_MASK, 32'hF);
        // bypassed filter with calibration
        wr(OFS_SETUP, 32'h40);
        chk("bypass", 32'h1, {31'h0, o_filter_bypass});
        s1 = 16'($urandom());
        s2 = 16'($urandom());
        conv(32'h87, 1'b1);
        rd(OFS_ZERO_ERR, {ofs_v[31:16], s1});
        rd(OFS_RESULT, {16'h0, s2 - s1});
        rd(OFS_COMMAND, 32'h83);
        rd(OFS_RAW, 32'hB);
        wr(OFS_STATE, 32'h1E);
        // continuous run, frozen setup, stop
        wr(OFS_SETUP, 32'hE4);
        chk("atten", 32'h2, {30'h0, o_attenuation});
        chk("osr", 32'h1, {30'h0, o_osr});
        wr(OFS_COMMAND, 32'h205);
        wait_busy(1'b1);
        wr(OFS_SETUP, 32'h0);
        rd(OFS_SETUP, 32'hE4);
        repeat (310) @(posedge i_clk);
        s2 = 16'($urandom());
        pulse(s2);
        repeat (3) @(posedge i_clk);
        rd(OFS_RESULT, {16'h0, s2 - s1});
        chk("busy", 32'h1, {31'h0, o_busy});
        chk("dma", 32'h1, {31'h0, o_dma_en});
        chk("analog_on", 32'h1, {31'h0, o_analog_on});
        wr(OFS_COMMAND, 32'h10);
        rd(OFS_COMMAND, 32'h2);
        chk("analog_on", 32'h0, {31'h0, o_analog_on});
        chk("dma", 32'h0, {31'h0, o_dma_en});
        chk("busy", 32'h0, {31'h0, o_busy});
        // register reset bit
        wr(OFS_UPPER, 32'h1234_5678);
        wr(OFS_COMMAND, 32'h8);
        rd(OFS_SETUP, 32'h0C);
        rd(OFS_UPPER, 32'h0FFF_FFFF);
        rd(OFS_COMMAND, 32'h0);
        rd(OFS_ZERO_ERR, {ofs_v[31:16], s1});
        chk("osr", 32'h3, {30'h0, o_osr});
        print_verdict();
    end
endmodule // tb_top
